// File: src/pswc_pkg.sv
package pswc_pkg;

    // register offsets on the plain register port
    localparam logic [7:0] power_control_reg_off = 8'h54;
    localparam logic [7:0] irq_status_reg_off    = 8'h58;
    localparam logic [7:0] byte_test_off         = 8'h64;
    localparam logic [7:0] phy_ctrl_off          = 8'h70;
    localparam logic [7:0] phy_mode_off          = 8'h74;
    localparam logic [7:0] phy_irq_src_off       = 8'h78;

    // power_control_reg fields
    localparam int ready_pos        = 0;
    localparam int pin_enable_pos   = 1;
    localparam int pin_pulse_pos    = 3;
    localparam int frame_wake_pos   = 9;
    localparam int carrier_wake_pos = 14;
    localparam int state_sel_lo     = 12;
    localparam int wake_src_lo      = 4;

    // irq_status_reg field
    localparam int wake_irq_pos = 17;

    // phy register fields
    localparam int phy_gen_down_pos     = 11;
    localparam int phy_energy_sleep_pos = 13;
    localparam int phy_energy_irq_pos   = 1;

    localparam logic [31:0] byte_test_value = 32'h87654321;

    typedef enum logic [1:0] {
        pswc_full  = 2'h0,
        pswc_light = 2'h1,
        pswc_deep  = 2'h2
    } pswc_mode_t;

    localparam logic [1:0] wake_src_none    = 2'h0;
    localparam logic [1:0] wake_src_carrier = 2'h1;
    localparam logic [1:0] wake_src_frame   = 2'h2;

    // timing
    localparam int clk_mhz           = 250;
    localparam int wake_pulse_ms     = 50;
    localparam int wake_pulse_cycles = wake_pulse_ms * 1000 * clk_mhz;
    localparam int ready_max_ms      = 2;
    localparam int ready_cycles      = 64;

endpackage

// File: src/pswc_ctrl_if.sv
`timescale 1ns/10ps
interface pswc_ctrl_if;
    logic       start;
    logic       pulse_mode;
    logic       stop;
    logic       active;
    modport ctl (output start, output pulse_mode, output stop, input active);
    modport tmr (input start, input pulse_mode, input stop, output active);
endinterface

// File: src/pswc_pin_timer.sv
`timescale 1ns/10ps
module pswc_pin_timer #(
    parameter int pulse_cycles = pswc_pkg::wake_pulse_cycles
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic srst,
    // control
    pswc_ctrl_if.tmr  ctl
);
    initial begin
        if (pulse_cycles < 1)
            $error("pulse_cycles must be at least one");
    end

    logic [31:0] count;
    logic        active;
    logic        pulsed;
    wire         run_out = pulsed && (count == 32'h1);

    always_ff @(posedge ref_clk) begin
        if (srst || ctl.stop || run_out) begin
            active <= 1'b0;
            pulsed <= 1'b0;
            count  <= 32'h0;
        end else if (ctl.start && !active) begin
            active <= 1'b1;
            pulsed <= ctl.pulse_mode;
            count  <= 32'(pulse_cycles);
        end else if (pulsed) begin
            count <= count - 32'h1;
        end
    end

    assign ctl.active = active;
endmodule

// File: src/pswc_power_state_wake.sv
`timescale 1ns/10ps
// Notes on behaviour
// R1: writing 01 enters light sleep
// R2: sleep clears ready, only control readable
// R3: host stays off bus until ready
// R4: byte test write wakes, mode resets
// R5: host reads once before writing
// R6: light sleep detects frames, status 10
// R7: frame wake asserts pin when enabled
// R8: wake irq status set regardless pin
// R9: host sets energy sleep before deep
// R10: deep sleep gates mac/bus, clears ready
// R11: carrier in deep sleep: pin, status 01
// R12: carrier already present detects immediately
// R13: host clears energy sleep after ready
// R14: wake irq sticky until source gone
// R15: pulse select: 50ms pulse or static
// R16: pin drops on status/enable clear
// R17: light sleep keeps phy, rx pm clocks
// R18: registers kept across sleep states
// R19: general power-down holds phy off
// R20: energy sleep powers phy down idle
// R21: energy return sets phy irq flag
// R22: ready within 2ms after wake write
// R23: mode reads 00, odd codes ignored
module pswc_power_state_wake #(
    parameter int pulse_cycles = pswc_pkg::wake_pulse_cycles,
    parameter int ready_cycles = pswc_pkg::ready_cycles
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // register port
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    // detectors
    input  wire logic        frame_detect,
    input  wire logic        line_energy_present,
    // clock gating and phy power
    output logic             mac_clk_en,
    output logic             bus_clk_en,
    output logic             rx_pm_clk_en,
    output logic             phy_clk_en,
    output logic             phy_power_down,
    output logic             phy_reset,
    // events
    output logic             wake_pin,
    output logic             host_irq
);
    initial begin
        if (ready_cycles < 1 || ready_cycles > 2 * 1000 * pswc_pkg::clk_mhz)
            $error("ready_cycles out of range");
    end

    pswc_pkg::pswc_mode_t state;
    logic        ready;
    logic        read_seen;
    logic        pin_enable;
    logic        pin_pulse;
    logic        frame_wake_enable;
    logic        carrier_wake_enable;
    logic [1:0]  wake_source_status;
    logic        wake_irq;
    logic        wake_irq_en;
    logic        phy_gen_down;
    logic        phy_energy_sleep;
    logic        phy_energy_irq;
    logic        energy_q;
    logic [31:0] ready_count;

    ////////////////////////////////////////////////////////////////
    // decode
    wire sleeping  = state != pswc_pkg::pswc_full;
    wire bus_open  = ready && read_seen; // R5
    wire wr_ok     = wr && bus_open;
    wire wr_pmc    = wr_ok && addr == pswc_pkg::power_control_reg_off;
    wire wr_irq    = wr_ok && addr == pswc_pkg::irq_status_reg_off;
    wire wr_phyc   = wr_ok && addr == pswc_pkg::phy_ctrl_off;
    wire wr_phym   = wr_ok && addr == pswc_pkg::phy_mode_off;
    wire wake_wr   = wr && sleeping && addr == pswc_pkg::byte_test_off; // R4
    wire [1:0] sel = wdata[pswc_pkg::state_sel_lo +: 2];
    wire go_light  = wr_pmc && sel == 2'h1; // R1 R23
    wire go_deep   = wr_pmc && sel == 2'h2; // R23

    // R6 R11 R12 (level energy: already present counts at once)
    wire frame_hit   = state == pswc_pkg::pswc_light && frame_detect;
    wire carrier_hit = state == pswc_pkg::pswc_deep && line_energy_present;

    wire [1:0] wsrc_wr = wr_pmc ? wdata[pswc_pkg::wake_src_lo +: 2] : 2'h0;
    wire [1:0] next_wake_source_status =
        {frame_hit, carrier_hit} | (wake_source_status & ~wsrc_wr);
    wire fen_n  = wr_pmc ? wdata[pswc_pkg::frame_wake_pos]   : frame_wake_enable;
    wire cen_n  = wr_pmc ? wdata[pswc_pkg::carrier_wake_pos] : carrier_wake_enable;
    wire pen_n  = wr_pmc ? wdata[pswc_pkg::pin_enable_pos]   : pin_enable;
    // R14 R16
    wire pme_src = (next_wake_source_status[1] && fen_n) ||
                   (next_wake_source_status[0] && cen_n);
    wire pme_rise = (frame_hit && fen_n) || (carrier_hit && cen_n);

    ////////////////////////////////////////////////////////////////
    // state and power control
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state <= pswc_pkg::pswc_full;
        end else if (wake_wr) begin
            state <= pswc_pkg::pswc_full; // R4
        end else if (go_light) begin
            state <= pswc_pkg::pswc_light; // R1
        end else if (go_deep) begin
            state <= pswc_pkg::pswc_deep;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst || go_light || go_deep) begin
            ready       <= !(go_light || go_deep); // R2 R10
            ready_count <= 32'h0;
        end else if (!ready && !sleeping) begin
            ready_count <= ready_count + 32'h1;
            ready       <= ready_count == 32'(ready_cycles - 1); // R22
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst || wake_wr || go_light || go_deep)
            read_seen <= 1'b0; // R5
        else if (rd && ready)
            read_seen <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////
    // configuration, status, irq (kept across sleep) R18
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pin_enable          <= 1'b0;
            pin_pulse           <= 1'b0;
            frame_wake_enable   <= 1'b0;
            carrier_wake_enable <= 1'b0;
            wake_source_status  <= pswc_pkg::wake_src_none;
            wake_irq            <= 1'b0;
            wake_irq_en         <= 1'b0;
            phy_gen_down        <= 1'b0;
            phy_energy_sleep    <= 1'b0;
            phy_energy_irq      <= 1'b0;
            energy_q            <= 1'b0;
        end else begin
            wake_source_status <= next_wake_source_status;
            frame_wake_enable  <= fen_n;
            carrier_wake_enable <= cen_n;
            pin_enable         <= pen_n;
            energy_q           <= line_energy_present;
            if (wr_pmc)
                pin_pulse <= wdata[pswc_pkg::pin_pulse_pos];
            // R8 R14: set wins; clear only once source gone
            if (pme_src)
                wake_irq <= 1'b1;
            else if (wr_irq && wdata[pswc_pkg::wake_irq_pos])
                wake_irq <= 1'b0;
            if (wr_irq)
                wake_irq_en <= wdata[0];
            if (wr_phyc)
                phy_gen_down <= wdata[pswc_pkg::phy_gen_down_pos];
            if (wr_phym)
                phy_energy_sleep <= wdata[pswc_pkg::phy_energy_sleep_pos];
            // R21: set wins over read-clear
            if (phy_energy_sleep && line_energy_present && !energy_q)
                phy_energy_irq <= 1'b1;
            else if (rd && bus_open && addr == pswc_pkg::phy_irq_src_off)
                phy_energy_irq <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // wake pin
    pswc_ctrl_if pin_if ();
    assign pin_if.start      = pme_rise && pen_n; // R7 R11
    assign pin_if.pulse_mode = pin_pulse; // R15
    assign pin_if.stop       = !pme_src || !pen_n; // R16

    pswc_pin_timer #(.pulse_cycles(pulse_cycles)) u_pin (
        .ref_clk (ref_clk),
        .srst    (srst),
        .ctl     (pin_if)
    );

    assign wake_pin = pin_if.active; // R15
    assign host_irq = wake_irq && wake_irq_en; // R8

    ////////////////////////////////////////////////////////////////
    // clock gating and phy power
    assign mac_clk_en     = !sleeping; // R10
    assign bus_clk_en     = !sleeping; // R10
    assign rx_pm_clk_en   = state != pswc_pkg::pswc_deep; // R17
    assign phy_clk_en     = state != pswc_pkg::pswc_deep; // R17
    // R19 R20
    assign phy_power_down = phy_gen_down || (phy_energy_sleep && !line_energy_present);

    // one-cycle phy reset when general power-down is released
    wire phy_wake_rst = wr_phyc && phy_gen_down && !wdata[pswc_pkg::phy_gen_down_pos];

    always_ff @(posedge ref_clk) begin
        if (srst)
            phy_reset <= 1'b0;
        else
            phy_reset <= phy_wake_rst; // R19
    end

    ////////////////////////////////////////////////////////////////
    // read path
    wire [31:0] pmc_word = {17'h0, carrier_wake_enable, 2'(state), 2'h0,
                            frame_wake_enable, 3'h0, wake_source_status, pin_pulse,
                            1'b0, pin_enable, ready};
    wire [31:0] rd_mux =
        addr == pswc_pkg::power_control_reg_off ? pmc_word :
        !bus_open                               ? 32'h0 : // R2
        addr == pswc_pkg::irq_status_reg_off    ?
            {14'h0, wake_irq, 16'h0, wake_irq_en} :
        addr == pswc_pkg::byte_test_off         ? pswc_pkg::byte_test_value :
        addr == pswc_pkg::phy_ctrl_off          ? {20'h0, phy_gen_down, 11'h0} :
        addr == pswc_pkg::phy_mode_off          ? {18'h0, phy_energy_sleep, 13'h0} :
        addr == pswc_pkg::phy_irq_src_off       ? {30'h0, phy_energy_irq, 1'b0} :
        32'h0;

    always_ff @(posedge ref_clk) begin
        if (srst)
            rdata <= 32'h0;
        else if (rd)
            rdata <= rd_mux;
    end
endmodule

// File: dv/pswc_props.sv
`timescale 1ns/10ps
module pswc_props (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        srst,
    // register port
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    // clocks and pin
    input wire logic        mac_clk_en,
    input wire logic        bus_clk_en,
    input wire logic        rx_pm_clk_en,
    input wire logic        phy_clk_en,
    input wire logic        wake_pin
);
    logic armed;
    wire  pc_hit = addr == pswc_pkg::power_control_reg_off;
    wire  pc_wr  = wr && pc_hit && armed && mac_clk_en;
    // writes count only after a read in full power
    always_ff @(posedge ref_clk) begin
        if (srst || (wr && addr == pswc_pkg::byte_test_off)) begin
            armed <= 1'b0;
        end else if (rd && mac_clk_en) begin
            armed <= 1'b1;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    property p_light;
        pc_wr && wdata[13:12] == 2'h1 |=> !mac_clk_en && !bus_clk_en && rx_pm_clk_en && phy_clk_en;
    endproperty
    a_light: assert property (p_light) else $error("light sleep entry wrong");
    property p_deep;
        pc_wr && wdata[13:12] == 2'h2 |=> !mac_clk_en && !bus_clk_en && !phy_clk_en;
    endproperty
    a_deep: assert property (p_deep) else $error("deep sleep entry wrong");
    property p_odd;
        pc_wr && wdata[13:12] == 2'h3 |=> mac_clk_en [*2];
    endproperty
    a_odd: assert property (p_odd) else $error("odd code left full power");
    property p_wake;
        wr && addr == pswc_pkg::byte_test_off && !mac_clk_en |=> mac_clk_en && phy_clk_en;
    endproperty
    a_wake: assert property (p_wake) else $error("wake write ignored");
    property p_pin_clr;
        pc_wr && (wdata[5:4] == 2'h3 || !wdata[1]) |-> ##[1:2] !wake_pin;
    endproperty
    a_pin_clr: assert property (p_pin_clr) else $error("pin stayed active");
    property p_gate;
        rd && !pc_hit && !mac_clk_en |=> rdata == 32'h0;
    endproperty
    a_gate: assert property (p_gate) else $error("gated read not zero");
    property p_rdy;
        rd && pc_hit && !mac_clk_en |=> !rdata[0];
    endproperty
    a_rdy: assert property (p_rdy) else $error("ready set in sleep");
    property p_mode;
        rd && pc_hit && mac_clk_en |=> rdata[13:12] == 2'h0;
    endproperty
    a_mode: assert property (p_mode) else $error("mode not 00 in full");
endmodule

bind pswc_power_state_wake pswc_props u_props (.*);

// File: dv/pswc_host_model.sv
`timescale 1ns/10ps
module pswc_host_model (
    // clock
    input wire logic   ref_clk,
    // register port
    output logic [7:0]  addr,
    output logic [31:0] wdata,
    output logic        wr,
    output logic        rd
);
    initial begin
        addr = 8'h0;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
    end
    // one-cycle strobe; released lines show inverted values
    task automatic op(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge ref_clk);
        wr <= 1'b0;
        rd <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask
endmodule

// File: dv/tb_pswc_power_state_wake.sv
`timescale 1ns/10ps
`define CMP(g, w) begin checks++; if ((g) !== (w)) begin err_total++; \
    $display("mismatch t=%0t got %h exp %h", $time, g, w); end end
module tb_pswc_power_state_wake;
    localparam logic [7:0] pc = pswc_pkg::power_control_reg_off;
    localparam logic [7:0] iq = pswc_pkg::irq_status_reg_off;
    localparam logic [7:0] bt = pswc_pkg::byte_test_off;
    localparam logic [7:0] pm = pswc_pkg::phy_mode_off;
    logic        ref_clk = 1'b0, srst = 1'b1, rd_d = 1'b0;
    logic        frame_detect = 1'b0, line_energy_present = 1'b0;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, seed = 32'h1e892c96;
    logic        wr, rd, mac_clk_en, bus_clk_en, rx_pm_clk_en, phy_clk_en;
    logic        phy_power_down, phy_reset, wake_pin, host_irq;
    logic [63:0] e, expq[$];
    int          err_total = 0, checks = 0, cyc = 0;
    initial forever #2 ref_clk = ~ref_clk;
    pswc_power_state_wake #(.pulse_cycles(20)) uut (.*);
    pswc_host_model u_host (.*);
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        expq.push_back({m, x});
        u_host.op(1'b0, a, 32'h0);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // read-data monitor and timeout
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        rd_d <= rd;
        if (rd_d) begin
            e = expq.pop_front();
            `CMP(rdata & e[63:32], e[31:0])
        end
        if (cyc == 3000) begin
            err_total++;
            give_verdict();
        end
    end
    initial begin
        repeat (20) @(posedge ref_clk);
        srst <= 1'b0;
        rchk(pc, 32'hffffffff, 32'h1);
        u_host.op(1'b1, pc, 32'h1202);
        rchk(pc, 32'h3233, 32'h1202);
        rchk(iq, 32'hffffffff, 32'h0);
        `CMP({mac_clk_en, bus_clk_en, rx_pm_clk_en, phy_clk_en}, 4'h3)
        @(posedge ref_clk) frame_detect <= 1'b1;
        @(posedge ref_clk) frame_detect <= 1'b0;
        tick(40);
        `CMP(wake_pin, 1'b1)
        rchk(pc, 32'h3233, 32'h1222);
        u_host.op(1'b1, bt, xs());
        tick(pswc_pkg::ready_cycles + 2);
        rchk(pc, 32'h3233, 32'h0223);
        rchk(iq, 32'h20000, 32'h20000);
        u_host.op(1'b1, pc, 32'h23a);
        tick(2);
        `CMP(wake_pin, 1'b0)
        u_host.op(1'b1, iq, 32'h20001);
        rchk(iq, 32'h20001, 32'h1);
        $display("test light sleep done");
        line_energy_present <= 1'b1;
        u_host.op(1'b1, pm, 32'h2000);
        u_host.op(1'b1, pc, 32'h600a);
        tick(3);
        `CMP({wake_pin, host_irq}, 2'h3)
        `CMP({mac_clk_en, bus_clk_en, phy_clk_en}, 3'h0)
        line_energy_present <= 1'b0;
        tick(25);
        `CMP(wake_pin, 1'b0)
        rchk(pc, 32'h3031, 32'h2010);
        u_host.op(1'b1, bt, xs());
        tick(pswc_pkg::ready_cycles + 2);
        rchk(pc, 32'h3031, 32'h0011);
        `CMP(phy_power_down, 1'b1)
        u_host.op(1'b1, pm, 32'h0);
        u_host.op(1'b1, pc, 32'h3000);
        rchk(pc, 32'h3001, 32'h1);
        u_host.op(1'b1, pswc_pkg::phy_ctrl_off, 32'h800);
        tick(1);
        `CMP({phy_power_down, phy_reset}, 2'h2)
        u_host.op(1'b1, pswc_pkg::phy_ctrl_off, 32'h0);
        #1;
        `CMP({phy_power_down, phy_reset}, 2'h1)
        $display("test deep sleep done");
        tick(2);
        give_verdict();
    end
endmodule
